// [gpp_pkg.sv]
/*
 * Constants and carrier types for the GPIO port block: register
 * selects, sub-register codes, reset values and pin index map.
 * Assumes eight ports of eight pins, flattened to a 64-bit vector
 * with port A in bits 7:0 and port H in bits 63:56.
 */
package gpp_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int NPIN = 64;

    // ************************************************************
    // Per-port register selects and sub-register codes
    // ************************************************************
    localparam logic [1:0] REG_ADDR = 2'h0;
    localparam logic [1:0] REG_CTL = 2'h1;
    localparam logic [1:0] REG_IN = 2'h2;
    localparam logic [1:0] REG_OUT = 2'h3;

    localparam logic [7:0] SUB_DIR = 8'h01;
    localparam logic [7:0] SUB_AF = 8'h02;
    localparam logic [7:0] SUB_EDGE = 8'h03;
    localparam logic [7:0] SUB_WAKE = 8'h04;
    localparam logic [7:0] SUB_ANY = 8'h05;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_ADDR = 8'h00;
    localparam logic [63:0] RST_DIR = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] RST_AF = 64'h0000_0000_0000_0000;
    localparam logic [63:0] RST_ZERO = 64'h0000_0000_0000_0000;
    localparam logic [7:0] RD_ZERO = 8'h00;

    // Pins whose interrupt may fire on both edges
    localparam logic [63:0] ANY_EDGE_OK = 64'h0000_0000_0000_00FF;

    // ************************************************************
    // Alternate function pin indices
    // ************************************************************
    localparam int IDX_SER0_RX = 4;
    localparam int IDX_SER0_TX = 5;
    localparam int IDX_SPI_SS = 18;
    localparam int IDX_SPI_SCK = 19;
    localparam int IDX_SPI_MOSI = 20;
    localparam int IDX_SPI_MISO = 21;
    localparam int IDX_SER1_RX = 28;
    localparam int IDX_SER1_TX = 29;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [63:0] out;
        logic [63:0] oe;
    } gpp_pin_drv_t;

    typedef struct packed {
        logic serial0_receive_pin;
        logic serial1_receive_pin;
        logic spi_ss;
        logic spi_sck;
        logic spi_mosi;
        logic spi_miso;
    } gpp_periph_in_t;

endpackage

// [gpp_sync.sv]
/*
 * Two-stage synchroniser for the 64 pin inputs.
 * Assumes pins are asynchronous to i_mclk; only the second stage
 * may be read by downstream logic.
 */
`timescale 1ns/1ps

module gpp_sync (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [63:0] i_async,
    output logic [63:0] o_sync
);
    import gpp_pkg::*;

    logic [63:0] meta_reg;
    logic [63:0] sync_reg;
    logic [63:0] meta_next;
    logic [63:0] sync_next;

    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            meta_reg <= RST_ZERO;
            sync_reg <= RST_ZERO;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;

endmodule

// [gpp_port.sv]
/*
 * GPIO port logic for eight ports of eight pins: indirect
 * direction and alternate-function sub-registers, pin drive,
 * input capture, edge interrupts and stop-mode pin wake-up.
 * Assumes a core-side register strobe on i_mclk, a stop-mode level
 * from the power controller that falls when the recovery delay
 * ends, and peripherals that own the alternate pin functions.
 */
// What this block does
// - Each pin may be a stop wake source; any level change starts recovery.
// - A pin wake pulses the watchdog stop-recovery flag set.
// - Input capture freezes in stop; only levels lasting past recovery land.
// - Short pulses may wake yet never reach capture or interrupts.
// - Interrupts on chosen rising or falling edge, or both edges on some pins.
// - Four registers per port; address and control give indirect access.
// - Address 01H makes control access the direction sub-register.
// - Direction 0 drives output data onto the pin.
// - Direction 1 tri-states the driver and samples the pin.
// - An enabled alternate function overrides the direction setting.
// - Address 02H selects alternate-function bits handing pins to peripherals.
// - Each alternate-function bit affects only its own pin.
// - Third port bits 2 to 5 carry SPI select, clock, MOSI, MISO.
// - Port A and D bits 4, 5 carry serial 0 and 1 receive, transmit.
`timescale 1ns/1ps

module gpp_port (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [2:0] i_port_sel,
    input wire logic [1:0] i_reg_sel,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data,
    input wire logic [63:0] i_pin_in,
    output gpp_pkg::gpp_pin_drv_t o_pin,
    input wire gpp_pkg::gpp_pin_drv_t i_alt_drv,
    output logic [63:0] o_alt_in,
    output gpp_pkg::gpp_periph_in_t o_periph,
    input wire logic i_stop_mode,
    output logic o_stop_recover,
    output logic o_wdt_stop_flag_set,
    output logic [63:0] o_pin_irq
);
    import gpp_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [63:0] addr_reg;
    logic [63:0] dir_reg;
    logic [63:0] af_reg;
    logic [63:0] edge_reg;
    logic [63:0] wake_reg;
    logic [63:0] any_reg;
    logic [63:0] outd_reg;
    logic [63:0] in_reg;
    logic [63:0] wref_reg;
    logic [63:0] irq_reg;
    logic [63:0] altin_reg;
    logic [63:0] pout_reg;
    logic [63:0] poe_reg;
    logic [7:0] rd_reg;
    logic wake_pulse_reg;
    logic [5:0] last_base_reg;

    logic [63:0] addr_next;
    logic [63:0] dir_next;
    logic [63:0] af_next;
    logic [63:0] edge_next;
    logic [63:0] wake_next;
    logic [63:0] any_next;
    logic [63:0] outd_next;
    logic [63:0] in_next;
    logic [63:0] irq_next;
    logic [63:0] altin_next;
    logic [63:0] pout_next;
    logic [63:0] poe_next;
    logic [7:0] rd_next;
    logic wake_pulse_next;

    logic [63:0] sync_pin;
    logic [5:0] base;
    logic [7:0] sub_sel;
    logic [63:0] rise;
    logic [63:0] fall;

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    gpp_sync u_sync (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_async(i_pin_in),
        .o_sync(sync_pin)
    );

    assign base = {i_port_sel, 3'h0};
    assign sub_sel = addr_reg[base +: 8];

    // ************************************************************
    // Register file: pointer and data pair per port
    // ************************************************************
    always_comb begin
        addr_next = addr_reg;
        dir_next = dir_reg;
        af_next = af_reg;
        edge_next = edge_reg;
        wake_next = wake_reg;
        any_next = any_reg;
        outd_next = outd_reg;
        if (i_wr_en) begin
            unique case (i_reg_sel)
                REG_ADDR: addr_next[base +: 8] = i_wr_data;
                REG_CTL: begin
                    // Unmapped sub-register codes ignore writes
                    if (sub_sel == SUB_DIR) begin
                        dir_next[base +: 8] = i_wr_data;
                    end else if (sub_sel == SUB_AF) begin
                        af_next[base +: 8] = i_wr_data;
                    end else if (sub_sel == SUB_EDGE) begin
                        edge_next[base +: 8] = i_wr_data;
                    end else if (sub_sel == SUB_WAKE) begin
                        wake_next[base +: 8] = i_wr_data;
                    end else if (sub_sel == SUB_ANY) begin
                        any_next[base +: 8] = i_wr_data;
                    end
                end
                REG_OUT: outd_next[base +: 8] = i_wr_data;
                REG_IN: begin
                end
            endcase
        end
    end

    // Read data is registered: it reflects selects of the prior edge
    always_comb begin
        rd_next = RD_ZERO;
        unique case (i_reg_sel)
            REG_ADDR: rd_next = addr_reg[base +: 8];
            REG_CTL: begin
                if (sub_sel == SUB_DIR) begin
                    rd_next = dir_reg[base +: 8];
                end else if (sub_sel == SUB_AF) begin
                    rd_next = af_reg[base +: 8];
                end else if (sub_sel == SUB_EDGE) begin
                    rd_next = edge_reg[base +: 8];
                end else if (sub_sel == SUB_WAKE) begin
                    rd_next = wake_reg[base +: 8];
                end else if (sub_sel == SUB_ANY) begin
                    rd_next = any_reg[base +: 8];
                end
            end
            REG_IN: rd_next = in_reg[base +: 8];
            REG_OUT: rd_next = outd_reg[base +: 8];
        endcase
    end

    // ************************************************************
    // Input capture, edges and wake-up
    // ************************************************************
    always_comb begin
        // Capture stalls in stop, so a pulse gone before recovery ends
        // leaves no trace in capture or interrupts
        in_next = i_stop_mode ? in_reg : sync_pin;
        rise = ~in_reg & in_next;
        fall = in_reg & ~in_next;
        // Single edge by polarity bit, both edges where allowed
        irq_next = (any_reg & ANY_EDGE_OK & (rise | fall))
            | (~(any_reg & ANY_EDGE_OK) & ~edge_reg & rise)
            | (~(any_reg & ANY_EDGE_OK) & edge_reg & fall);
        // Wake compares against the live synchronised level, not the
        // frozen capture, so even a short pulse is seen
        wake_pulse_next = i_stop_mode && |(wake_reg & (sync_pin ^ wref_reg));
        altin_next = af_reg & sync_pin;
    end

    // ************************************************************
    // Pin drive, one slice per pin
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            always_comb begin
                if (af_reg[g]) begin
                    pout_next[g] = i_alt_drv.out[g];
                    poe_next[g] = i_alt_drv.oe[g];
                end else begin
                    pout_next[g] = outd_reg[g];
                    poe_next[g] = ~dir_reg[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            addr_reg <= {8{RST_ADDR}};
            dir_reg <= RST_DIR;
            af_reg <= RST_AF;
            edge_reg <= RST_ZERO;
            wake_reg <= RST_ZERO;
            any_reg <= RST_ZERO;
            outd_reg <= RST_ZERO;
            in_reg <= RST_ZERO;
            wref_reg <= RST_ZERO;
            irq_reg <= RST_ZERO;
            altin_reg <= RST_ZERO;
            pout_reg <= RST_ZERO;
            poe_reg <= RST_ZERO;
            rd_reg <= RD_ZERO;
            wake_pulse_reg <= 1'b0;
            last_base_reg <= 6'h00;
        end else begin
            addr_reg <= addr_next;
            dir_reg <= dir_next;
            af_reg <= af_next;
            edge_reg <= edge_next;
            wake_reg <= wake_next;
            any_reg <= any_next;
            outd_reg <= outd_next;
            in_reg <= in_next;
            wref_reg <= sync_pin;
            irq_reg <= irq_next;
            altin_reg <= altin_next;
            pout_reg <= pout_next;
            poe_reg <= poe_next;
            rd_reg <= rd_next;
            wake_pulse_reg <= wake_pulse_next;
            last_base_reg <= base;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_rd_data = rd_reg;
    assign o_pin.out = pout_reg;
    assign o_pin.oe = poe_reg;
    assign o_alt_in = altin_reg;
    assign o_pin_irq = irq_reg;
    assign o_stop_recover = wake_pulse_reg;
    assign o_wdt_stop_flag_set = wake_pulse_reg;
    assign o_periph.serial0_receive_pin = altin_reg[IDX_SER0_RX];
    assign o_periph.serial1_receive_pin = altin_reg[IDX_SER1_RX];
    assign o_periph.spi_ss = altin_reg[IDX_SPI_SS];
    assign o_periph.spi_sck = altin_reg[IDX_SPI_SCK];
    assign o_periph.spi_mosi = altin_reg[IDX_SPI_MOSI];
    assign o_periph.spi_miso = altin_reg[IDX_SPI_MISO];

    // ************************************************************
    // Checks
    // ************************************************************
    chk_wake_start: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (i_stop_mode && |(wake_reg & (sync_pin ^ wref_reg)))
            |=> o_stop_recover)
        else $error("enabled pin change in stop did not wake");

    chk_wake_flag: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        $rose(o_stop_recover) |-> o_wdt_stop_flag_set && $past(i_stop_mode))
        else $error("stop flag set not paired with wake");

    chk_capture_frozen: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        i_stop_mode |=> in_reg == $past(in_reg))
        else $error("input capture changed during stop");

    chk_no_irq_stop: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        i_stop_mode |=> o_pin_irq == RST_ZERO)
        else $error("pin interrupt raised during stop");

    chk_rise_irq: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (!i_stop_mode && !in_reg[0] && sync_pin[0] && !edge_reg[0])
            |=> o_pin_irq[0])
        else $error("rising edge on pin 0 gave no interrupt");

    chk_pin_drive: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        ##1 o_pin.oe == (($past(af_reg) & $past(i_alt_drv.oe))
            | ~($past(af_reg) | $past(dir_reg))))
        else $error("pin enable does not follow direction or override");

    chk_ctl_read: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (i_reg_sel == REG_CTL && sub_sel == SUB_DIR)
            |=> o_rd_data == $past(dir_reg[base +: 8]))
        else $error("control read missed direction sub-register");

    chk_af_write: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (i_wr_en && i_reg_sel == REG_CTL && sub_sel == SUB_AF)
            |=> af_reg[last_base_reg +: 8] == $past(i_wr_data)
            && dir_reg == $past(dir_reg))
        else $error("alternate function write went astray");

    chk_spi_map: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        ##1 o_periph.spi_sck == ($past(af_reg[IDX_SPI_SCK])
            & $past(sync_pin[IDX_SPI_SCK])))
        else $error("SPI clock not routed from port C bit 3");

    chk_uart_map: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        ##1 o_periph.serial1_receive_pin == ($past(af_reg[IDX_SER1_RX])
            & $past(sync_pin[IDX_SER1_RX])))
        else $error("serial 1 receive not routed from port D bit 4");

endmodule

// [gpp_pin_model.sv]
/*
 * Pin-side partner for the GPIO port: resolves every pad from the
 * device driver, an external source and a weak pull-up.
 * Assumes the bench changes external levels at the falling edge.
 */
`timescale 1ns/1ps

module gpp_pin_model (
    input wire gpp_pkg::gpp_pin_drv_t i_drv,
    input wire logic [63:0] i_ext_en,
    input wire logic [63:0] i_ext_lvl,
    output logic [63:0] o_pad
);
    import gpp_pkg::*;

    // ************************************************************
    // Pad resolution
    // ************************************************************
    // Device driver wins; a released pad floats to the pull-up level,
    // never to the last driven value
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (i_drv.oe[i]) begin
                o_pad[i] = i_drv.out[i];
            end else if (i_ext_en[i]) begin
                o_pad[i] = i_ext_lvl[i];
            end else begin
                o_pad[i] = 1'b1;
            end
        end
    end
endmodule

// [tb.sv]
/*
 * Self-checking bench for the GPIO port: register tasks, pin drive,
 * capture, alternate functions, edge interrupts and stop wake-up.
 * Assumes gpp_port and gpp_pin_model are compiled beforehand.
 */
`timescale 1ns/1ps

module tb;
    import gpp_pkg::*;

    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic [2:0] port_sel;
    logic [1:0] reg_sel;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [63:0] pad;
    gpp_pin_drv_t pin_drv;
    gpp_pin_drv_t alt_drv;
    logic [63:0] alt_in;
    gpp_periph_in_t periph;
    logic stop_mode;
    logic stop_recover;
    logic wdt_set;
    logic [63:0] pin_irq;
    logic [63:0] ext_lvl;
    logic [63:0] ext_en;
    int failures = 0;
    int checks_done = 0;
    int irq_cnt = 0;
    int wake_cnt = 0;
    int flag_cnt = 0;

    always #2.5 i_mclk = ~i_mclk;

    gpp_port uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_port_sel(port_sel),
        .i_reg_sel(reg_sel), .i_wr_en(wr_en), .i_wr_data(wr_data),
        .o_rd_data(rd_data), .i_pin_in(pad), .o_pin(pin_drv),
        .i_alt_drv(alt_drv), .o_alt_in(alt_in), .o_periph(periph),
        .i_stop_mode(stop_mode), .o_stop_recover(stop_recover),
        .o_wdt_stop_flag_set(wdt_set), .o_pin_irq(pin_irq));

    gpp_pin_model pins (.i_drv(pin_drv), .i_ext_en(ext_en),
        .i_ext_lvl(ext_lvl), .o_pad(pad));

    // Pulses last one cycle, so count them at every edge
    always @(posedge i_mclk) begin
        if (pin_irq !== 64'h0) irq_cnt++;
        if (stop_recover === 1'b1) wake_cnt++;
        if (wdt_set === 1'b1) flag_cnt++;
    end

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string msg);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] p, input logic [1:0] r,
                      input logic [7:0] d);
        @(negedge i_mclk);
        port_sel = p;
        reg_sel = r;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge i_mclk);
        wr_en = 1'b0;
    endtask

    task automatic rdchk(input logic [2:0] p, input logic [1:0] r,
                         input logic [7:0] exp, input string msg);
        @(negedge i_mclk);
        port_sel = p;
        reg_sel = r;
        @(negedge i_mclk);
        chk8(rd_data, exp, msg);
    endtask

    task automatic sub_wr(input logic [2:0] p, input logic [7:0] code,
                          input logic [7:0] d);
        wr(p, REG_ADDR, code);
        wr(p, REG_CTL, d);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic end_of_test;
        $display("failures=%0d checks_done=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Under two hundred cycles are expected; this is twenty times that
    initial begin
        #20000;
        failures++;
        $display("BAD t=%0t watchdog expired", $time);
        end_of_test();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        port_sel = 3'h0;
        reg_sel = REG_ADDR;
        wr_en = 1'b0;
        wr_data = 8'h00;
        alt_drv = '0;
        stop_mode = 1'b0;
        ext_lvl = 64'h0;
        ext_en = 64'hFFFF_FFFF_FFFF_FFFF;
        wait_n(16);
        i_nrst = 1'b1;
        chk8({7'h0, |pin_drv.oe}, 8'h00, "drivers off at reset");
        rdchk(3'h0, REG_ADDR, RST_ADDR, "address reset");
        wr(3'h0, REG_ADDR, SUB_DIR);
        rdchk(3'h0, REG_CTL, 8'hFF, "direction reset");
        wr(3'h0, REG_ADDR, SUB_AF);
        rdchk(3'h0, REG_CTL, 8'h00, "alt function reset");
        // Output data first, then turn the low nibble to outputs
        wr(3'h1, REG_OUT, 8'hA5);
        sub_wr(3'h1, SUB_DIR, 8'hF0);
        wait_n(2);
        chk8(pin_drv.oe[15:8], 8'h0F, "port B enables");
        chk8({4'h0, pin_drv.out[11:8]}, 8'h05, "port B drive");
        chk8(pin_drv.oe[7:0], 8'h00, "port A untouched");
        rdchk(3'h1, REG_CTL, 8'hF0, "direction readback");
        wr(3'h1, REG_ADDR, 8'h07);
        rdchk(3'h1, REG_CTL, 8'h00, "unused code reads zero");
        wr(3'h1, REG_CTL, 8'h55);
        wr(3'h1, REG_ADDR, SUB_DIR);
        rdchk(3'h1, REG_CTL, 8'hF0, "direction kept");
        // Capture must lag the pad through the synchroniser
        ext_lvl[39:32] = 8'h3C;
        wait_n(4);
        ext_lvl[39:32] = 8'hC3;
        rdchk(3'h4, REG_IN, 8'h3C, "capture not bypassed");
        wait_n(3);
        rdchk(3'h4, REG_IN, 8'hC3, "capture lands");
        // SPI pins on port C; bit 6 stays a plain input
        ext_lvl[23:16] = 8'h7C;
        alt_drv.oe[22:21] = 2'b11;
        alt_drv.out[22:21] = 2'b11;
        sub_wr(3'h2, SUB_AF, 8'h3C);
        wait_n(4);
        chk8({3'h0, periph.spi_ss, periph.spi_sck, periph.spi_mosi,
              periph.spi_miso, alt_in[22]}, 8'h1E, "spi inputs");
        chk8({5'h0, pin_drv.oe[22:21], pin_drv.out[21]}, 8'h03,
             "alt drive");
        alt_drv = '0;
        // Serial receive and transmit on ports A and D
        ext_lvl[4] = 1'b1;
        ext_lvl[28] = 1'b1;
        alt_drv.oe[5] = 1'b1;
        alt_drv.oe[29] = 1'b1;
        sub_wr(3'h0, SUB_AF, 8'h30);
        sub_wr(3'h3, SUB_AF, 8'h30);
        wait_n(4);
        chk8({4'h0, periph.serial0_receive_pin, periph.serial1_receive_pin,
              pin_drv.oe[5], pin_drv.oe[29]}, 8'h0F, "serial pins");
        // Rising, falling and both-edge modes on pin A0
        for (int m = 0; m < 3; m++) begin
            sub_wr(3'h0, SUB_EDGE, (m == 1) ? 8'h01 : 8'h00);
            sub_wr(3'h0, SUB_ANY, (m == 2) ? 8'h01 : 8'h00);
            wait_n(2);
            irq_cnt = 0;
            ext_lvl[0] = 1'b1;
            wait_n(6);
            chk8(8'(irq_cnt), (m == 1) ? 8'h00 : 8'h01, "rise irq");
            ext_lvl[0] = 1'b0;
            wait_n(6);
            chk8(8'(irq_cnt), (m == 2) ? 8'h02 : 8'h01, "fall irq");
        end
        rdchk(3'h0, REG_CTL, 8'h01, "both-edge readback");
        // Stop: short pulse on a wake pin, lasting change on another
        sub_wr(3'h4, SUB_WAKE, 8'h01);
        rdchk(3'h4, REG_CTL, 8'h01, "wake enable readback");
        stop_mode = 1'b1;
        wait_n(2);
        irq_cnt = 0;
        wake_cnt = 0;
        flag_cnt = 0;
        ext_lvl[33:32] = 2'b00;
        wait_n(2);
        ext_lvl[33:32] = 2'b11;
        ext_lvl[35] = 1'b1;
        wait_n(6);
        chk8(8'(wake_cnt), 8'h02, "wake on each change");
        chk8(8'(flag_cnt), 8'h02, "watchdog flag set");
        chk8(8'(irq_cnt), 8'h00, "no irq in stop");
        wr(3'h4, REG_IN, 8'h00);
        rdchk(3'h4, REG_IN, 8'hC3, "capture frozen");
        stop_mode = 1'b0;
        wait_n(4);
        rdchk(3'h4, REG_IN, 8'hCB, "lasting level lands");
        // Released pads float to the pull-up level
        ext_en[47:40] = 8'h00;
        wait_n(4);
        rdchk(3'h5, REG_IN, 8'hFF, "released pins read high");
        end_of_test();
    end
endmodule
